// file: core/ref_input_pkg.sv
// shared constants and types for the reference input conditioning block
package ref_input_pkg;

   // stage and index counts
   localparam int NUM_STAGES    = 8;
   localparam int NUM_IDX       = 16;
   localparam int NUM_GPIO      = 16;
   localparam int SE_IDX_OFFSET = 8;
   localparam int NUM_PINS      = 2 * NUM_STAGES + NUM_GPIO;

   // frequency fraction widths
   localparam int FREQ_M_W = 48;
   localparam int FREQ_N_W = 16;

   // input divider holds divisor minus one, so 2..65536 fits in 16 bits
   localparam int          DIV_W      = 16;
   localparam logic [15:0] DIV_M1_MIN = 16'h0001;

   // system pll feedback divider limits and reset value
   localparam int         FB_DIV_W   = 10;
   localparam logic [9:0] FB_DIV_MIN = 10'h06c;
   localparam logic [9:0] FB_DIV_MAX = 10'h22c;
   localparam logic [9:0] FB_DIV_RST = 10'h100;

   // loop filter control voltage window for lock
   localparam int         VCTRL_W         = 8;
   localparam logic [7:0] VCTRL_MID       = 8'h80;
   localparam logic [7:0] LOCK_MARGIN_X1  = 8'h40;
   localparam logic [7:0] LOCK_MARGIN_X2  = 8'h30;

   // loss-of-lock filter time, rounded up to clock cycles
   localparam int CLK_PERIOD_PS  = 5000;
   localparam int LOL_FILTER_NS  = 1000;
   localparam int LOL_FILTER_CYC = (LOL_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LOL_CNT_W      = 8;

   // gpio that feeds index stage+8 in differential-plus-gpio mode
   localparam logic [7:0][3:0] GPIO_PAIR = {4'h3, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf, 4'h0};

   typedef enum logic [2:0] {
      MODE_DIFF      = 3'b001,
      MODE_DUAL_SE   = 3'b010,
      MODE_DIFF_GPIO = 3'b100
   } in_mode_t;

   typedef enum logic [1:0] {
      ST_LOAD = 2'b01,
      ST_RUN  = 2'b10
   } pll_state_t;

   typedef struct packed {
      logic [FREQ_M_W-1:0] m;
      logic [FREQ_N_W-1:0] n;
   } freq_t;

   typedef struct packed {
      logic             bypass;
      logic             invert;
      logic [DIV_W-1:0] div_m1;
   } path_cfg_t;

   typedef struct packed {
      in_mode_t  mode;
      logic      buf_nmos;
      path_cfg_t pos;
      path_cfg_t neg;
   } stage_cfg_t;

   typedef struct packed {
      logic                doubler_en;
      logic [FB_DIV_W-1:0] fb_div;
   } sys_pll_ctrl_t;

   localparam sys_pll_ctrl_t SYS_PLL_RST = '{doubler_en: 1'b0, fb_div: FB_DIV_RST};

endpackage : ref_input_pkg

// file: core/reference_input_conditioning.sv
// reference input stages, internal clock routing and system pll control
// How it works
// - frequencies held as 48-bit over 16-bit fraction
// - pll control selects crystal direct or doubled
// - feedback divider accepts 108 through 556 only
// - reset loads pll control from valid enabled source
// - after reset, host rewrites pll control anytime
// - lock limits derived internally; alarm to status, gpio
// - stage mode: differential, dual single-ended, diff plus gpio
// - differential mode gives stage index; buffer select
// - divided paths divide 2 to 65536 or bypass
// - inverted path before divider picks falling edge
// - dual single-ended: positive index, negative index plus 8
// - edge polarity chosen separately per path
// - gpio mode only on listed stages, fixed pairing
// - gpio path has no divider
// - buffer select ignored on dual single-ended only, kept in diff plus gpio mode
// - each input can be disabled
// - any input may be a sync pulse for another
`timescale 1ns/1ps
`default_nettype none

module reference_input_conditioning
   import ref_input_pkg::*;
#(
   parameter logic [NUM_STAGES-1:0] GPIO_STAGE_MASK = 8'hff
) (
   input  wire  logic                          i_core_clk,
   input  wire  logic                          i_sys_rst,
   input  wire  logic [NUM_STAGES-1:0]         i_clk_p,
   input  wire  logic [NUM_STAGES-1:0]         i_clk_n,
   input  wire  logic [NUM_GPIO-1:0]           i_gpio,
   input  wire  stage_cfg_t [NUM_STAGES-1:0]   i_stage_cfg,
   input  wire  logic [NUM_IDX-1:0]            i_in_disable,
   input  wire  logic [NUM_IDX-1:0]            i_sync_en,
   input  wire  logic [NUM_IDX-1:0][3:0]       i_sync_assoc,
   input  wire  freq_t [NUM_IDX-1:0]           i_freq,
   input  wire  logic                          i_otp_en,
   input  wire  logic                          i_otp_valid,
   input  wire  sys_pll_ctrl_t                 i_otp_ctrl,
   input  wire  logic                          i_eeprom_en,
   input  wire  logic                          i_eeprom_valid,
   input  wire  sys_pll_ctrl_t                 i_eeprom_ctrl,
   input  wire  logic                          i_reset_seq_done,
   input  wire  logic                          i_host_wr,
   input  wire  sys_pll_ctrl_t                 i_host_ctrl,
   input  wire  logic [VCTRL_W-1:0]            i_vctrl,
   input  wire  logic                          i_lol_gpio_en,
   output var   logic [NUM_IDX-1:0]            o_ref_edge,
   output var   logic [NUM_STAGES-1:0]         o_buf_nmos,
   output var   logic [NUM_IDX-1:0]            o_sync_flag,
   output var   logic [NUM_IDX-1:0][3:0]       o_sync_assoc,
   output var   freq_t [NUM_IDX-1:0]           o_freq,
   output var   sys_pll_ctrl_t                 o_pll_ctrl,
   output var   logic                          o_pll_loaded,
   output var   logic                          o_pll_cfg_reject,
   output var   logic                          o_pll_lol,
   output var   logic                          o_gpio_lol
);

   // pin synchroniser chain: p pins, n pins, then gpios
   logic [NUM_PINS-1:0]    pins;
   logic [NUM_PINS-1:0]    pin_s1_reg;
   logic [NUM_PINS-1:0]    pin_s2_reg;
   logic [NUM_PINS-1:0]    pin_s3_reg;
   logic [NUM_PINS-1:0]    stab_reg;
   logic [VCTRL_W-1:0]     vc_s1_reg;
   logic [VCTRL_W-1:0]     vc_s2_reg;
   logic [VCTRL_W-1:0]     vc_s3_reg;
   logic [VCTRL_W-1:0]     vc_stab_reg;
   logic [NUM_IDX-1:0]     edge_reg;
   pll_state_t             st_reg;
   logic [LOL_CNT_W-1:0]   oow_cnt_reg;
   logic [VCTRL_W-1:0]     lock_lo;
   logic [VCTRL_W-1:0]     lock_hi;
   logic                   in_win;
   logic                   host_ok;

   assign pins = {i_gpio, i_clk_n, i_clk_p};

   // feedback divider range check
   function automatic logic fb_ok(input sys_pll_ctrl_t c);
      fb_ok = (c.fb_div >= FB_DIV_MIN) && (c.fb_div <= FB_DIV_MAX);
   endfunction : fb_ok

   // three-stage sampling; a level counts once stages two and three agree
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         pin_s3_reg <= '0;
         stab_reg   <= '0;
      end else begin
         pin_s1_reg <= pins;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         // take the level where stages two and three agree, otherwise hold the last settled level
         stab_reg   <= (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg)) | (stab_reg & (pin_s2_reg ^ pin_s3_reg));
      end
   end

   // per internal index: source select, edge select, divider
   for (genvar i = 0; i < NUM_IDX; i++) begin : g_idx
      localparam int S = i % NUM_STAGES;
      logic             src_lvl;
      logic             src_prev_reg;
      logic             present;
      logic             sel_edge;
      logic             cfg_same;
      logic [DIV_W-1:0] lim;
      logic [DIV_W-1:0] cnt_reg;
      path_cfg_t        pc;
      path_cfg_t        pc_prev_reg;

      if (i < NUM_STAGES) begin : g_pos
         // positive pin always carries the stage index
         always_comb begin
            src_lvl = stab_reg[i];
            pc      = i_stage_cfg[S].pos;
            present = !i_in_disable[i];
         end
      end else begin : g_hi
         // index plus 8 comes from the negative pin or the paired gpio
         always_comb begin
            src_lvl = 1'b0;
            pc      = i_stage_cfg[S].neg;
            present = 1'b0;
            case (i_stage_cfg[S].mode)
               MODE_DUAL_SE: begin
                  src_lvl = stab_reg[SE_IDX_OFFSET + S];
                  present = !i_in_disable[i];
               end
               MODE_DIFF_GPIO: begin
                  src_lvl   = stab_reg[2 * NUM_STAGES + int'(GPIO_PAIR[S])];
                  present   = GPIO_STAGE_MASK[S] && !i_in_disable[i];
                  pc.bypass = 1'b1;
               end
               default: begin
                  src_lvl = 1'b0;
                  present = 1'b0;
               end
            endcase
         end
      end

      // divisor of at least two; inverted path selects the falling edge
      assign lim      = (pc.div_m1 < DIV_M1_MIN) ? DIV_M1_MIN : pc.div_m1;
      assign sel_edge = pc.invert ? (src_prev_reg && !src_lvl)
                                  : (!src_prev_reg && src_lvl);
      assign cfg_same = (pc == pc_prev_reg);

      // edge history and config snapshot, local to this index only
      always_ff @(posedge i_core_clk) begin
         if (i_sys_rst) begin
            src_prev_reg <= 1'b0;
            pc_prev_reg  <= '0;
         end else begin
            src_prev_reg <= src_lvl;
            pc_prev_reg  <= pc;
         end
      end

      // divider counter restarts on reset, while the path is absent or disabled, and on its own path's config change
      always_ff @(posedge i_core_clk) begin
         if (i_sys_rst || !present || !cfg_same) begin
            cnt_reg <= '0;
         end else if (sel_edge) begin
            cnt_reg <= (cnt_reg >= lim) ? '0 : cnt_reg + 16'h0001;
         end
      end

      // one pulse per divided (or bypassed) selected edge
      always_ff @(posedge i_core_clk) begin
         if (i_sys_rst) begin
            edge_reg[i] <= 1'b0;
         end else begin
            edge_reg[i] <= present && sel_edge && cfg_same && (pc.bypass || cnt_reg >= lim);
         end
      end

      property p_disabled_silent;
         @(posedge i_core_clk) disable iff (i_sys_rst)
         i_in_disable[i] |=> !o_ref_edge[i];
      endproperty
      a_disabled_silent : assert property (p_disabled_silent)
         else $error("disabled input produced an edge");

      if (i >= NUM_STAGES) begin : g_chk
         property p_diff_only_single;
            @(posedge i_core_clk) disable iff (i_sys_rst)
            (i_stage_cfg[S].mode == MODE_DIFF) |=> !o_ref_edge[i];
         endproperty
         a_diff_only_single : assert property (p_diff_only_single)
            else $error("index plus 8 active in differential-only mode");
      end
   end

   assign o_ref_edge = edge_reg;

   // buffer select reaches only the differential path of a stage
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_buf_nmos <= '0;
      end else begin
         for (int s = 0; s < NUM_STAGES; s++) begin
            o_buf_nmos[s] <= i_stage_cfg[s].buf_nmos && (i_stage_cfg[s].mode != MODE_DUAL_SE);
         end
      end
   end

   for (genvar s = 0; s < NUM_STAGES; s++) begin : g_buf_chk
      property p_buf_ignored;
         @(posedge i_core_clk) disable iff (i_sys_rst)
         (i_stage_cfg[s].mode == MODE_DUAL_SE) |=> !o_buf_nmos[s];
      endproperty
      a_buf_ignored : assert property (p_buf_ignored)
         else $error("buffer select active on single-ended stage");
   end

   // sync designation and nominal frequencies passed to the channels
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_sync_flag  <= '0;
         o_sync_assoc <= '0;
         o_freq       <= '0;
      end else begin
         o_sync_flag  <= i_sync_en & ~i_in_disable;
         o_sync_assoc <= i_sync_assoc;
         o_freq       <= i_freq;
      end
   end

   // system pll control: load at reset, host rewrites afterwards
   assign host_ok = i_host_wr && fb_ok(i_host_ctrl);

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         st_reg           <= ST_LOAD;
         o_pll_ctrl       <= SYS_PLL_RST;
         o_pll_loaded     <= 1'b0;
         o_pll_cfg_reject <= 1'b0;
      end else begin
         o_pll_cfg_reject <= 1'b0;
         case (st_reg)
            ST_LOAD: begin
               o_pll_cfg_reject <= i_host_wr;
               if (i_reset_seq_done) begin
                  if (i_otp_en && i_otp_valid && fb_ok(i_otp_ctrl)) begin
                     o_pll_ctrl <= i_otp_ctrl;
                  end else if (i_eeprom_en && i_eeprom_valid && fb_ok(i_eeprom_ctrl)) begin
                     o_pll_ctrl <= i_eeprom_ctrl;
                  end
                  o_pll_loaded <= 1'b1;
                  st_reg       <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (host_ok) begin
                  o_pll_ctrl <= i_host_ctrl;
               end
               o_pll_cfg_reject <= i_host_wr && !host_ok;
            end
            default: begin
               st_reg <= ST_LOAD;
            end
         endcase
      end
   end

   property p_fb_range;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (o_pll_ctrl.fb_div >= FB_DIV_MIN) && (o_pll_ctrl.fb_div <= FB_DIV_MAX);
   endproperty
   a_fb_range : assert property (p_fb_range)
      else $error("feedback divider out of range");

   property p_load_otp;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (st_reg == ST_LOAD && i_reset_seq_done && i_otp_en && i_otp_valid && fb_ok(i_otp_ctrl))
      |=> (o_pll_ctrl == $past(i_otp_ctrl)) && o_pll_loaded;
   endproperty
   a_load_otp : assert property (p_load_otp)
      else $error("otp contents not loaded at reset");

   property p_no_host_in_load;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (st_reg == ST_LOAD && !i_reset_seq_done) |=> $stable(o_pll_ctrl);
   endproperty
   a_no_host_in_load : assert property (p_no_host_in_load)
      else $error("pll control changed before reset sequence done");

   property p_host_accept;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (st_reg == ST_RUN && host_ok) |=> (o_pll_ctrl == $past(i_host_ctrl)) && !o_pll_cfg_reject;
   endproperty
   a_host_accept : assert property (p_host_accept)
      else $error("valid host write not taken");

   // control voltage sampled like the pins
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         vc_s1_reg   <= '0;
         vc_s2_reg   <= '0;
         vc_s3_reg   <= '0;
         vc_stab_reg <= VCTRL_MID;
      end else begin
         vc_s1_reg <= i_vctrl;
         vc_s2_reg <= vc_s1_reg;
         vc_s3_reg <= vc_s2_reg;
         if (vc_s2_reg == vc_s3_reg) begin
            vc_stab_reg <= vc_s3_reg;
         end
      end
   end

   // lock window derived from the selected configuration
   always_comb begin
      lock_lo = VCTRL_MID - (o_pll_ctrl.doubler_en ? LOCK_MARGIN_X2 : LOCK_MARGIN_X1);
      lock_hi = VCTRL_MID + (o_pll_ctrl.doubler_en ? LOCK_MARGIN_X2 : LOCK_MARGIN_X1);
      in_win  = (vc_stab_reg >= lock_lo) && (vc_stab_reg <= lock_hi);
   end

   // out-of-window time filter; alarm to status and optional gpio
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         oow_cnt_reg <= '0;
         o_pll_lol   <= 1'b1;
         o_gpio_lol  <= 1'b0;
      end else begin
         if (st_reg != ST_RUN || in_win) begin
            oow_cnt_reg <= '0;
         end else if (oow_cnt_reg != LOL_CNT_W'(LOL_FILTER_CYC)) begin
            oow_cnt_reg <= oow_cnt_reg + 8'h01;
         end
         o_pll_lol  <= (st_reg != ST_RUN) || (oow_cnt_reg == LOL_CNT_W'(LOL_FILTER_CYC));
         o_gpio_lol <= i_lol_gpio_en &&
                       ((st_reg != ST_RUN) || (oow_cnt_reg == LOL_CNT_W'(LOL_FILTER_CYC)));
      end
   end

   property p_lol_clears;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (st_reg == ST_RUN && in_win) [*2] |=> !o_pll_lol;
   endproperty
   a_lol_clears : assert property (p_lol_clears)
      else $error("loss of lock held while in window");

   property p_gpio_follows;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      o_gpio_lol |-> o_pll_lol && $past(i_lol_gpio_en);
   endproperty
   a_gpio_follows : assert property (p_gpio_follows)
      else $error("gpio alarm without status alarm");

endmodule : reference_input_conditioning

`default_nettype wire

// file: test/ref_source_model.sv
// burst clock source standing in for the external reference pins
`timescale 1ns/1ps
`default_nettype none
module ref_source_model
   import ref_input_pkg::*;
#(
   parameter int HALF_CYC = 4
) (
   input  wire logic                  i_core_clk,
   input  wire logic                  i_sys_rst,
   input  wire logic                  i_start,
   input  wire logic [7:0]            i_burst,
   input  wire logic [NUM_STAGES-1:0] i_mask_p,
   input  wire logic [NUM_STAGES-1:0] i_mask_n,
   input  wire logic [NUM_GPIO-1:0]   i_mask_g,
   output var  logic [NUM_STAGES-1:0] o_clk_p,
   output var  logic [NUM_STAGES-1:0] o_clk_n,
   output var  logic [NUM_GPIO-1:0]   o_gpio,
   output var  logic                  o_busy
);
   logic [7:0] left_reg;
   logic [7:0] tick_reg;
   logic       lvl_reg;
   // transitions spaced so every level outlasts the pin sampler
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         left_reg <= 8'h00;
         tick_reg <= 8'h00;
         lvl_reg  <= 1'b0;
      end else if (i_start) begin
         left_reg <= i_burst;
         tick_reg <= 8'h00;
      end else if (left_reg != 8'h00) begin
         if (tick_reg == 8'(HALF_CYC - 1)) begin
            tick_reg <= 8'h00;
            lvl_reg  <= ~lvl_reg;
            left_reg <= left_reg - 8'h01;
         end else begin
            tick_reg <= tick_reg + 8'h01;
         end
      end
   end
   // pins outside the mask stand still low between and during bursts
   assign o_clk_p = i_mask_p & {NUM_STAGES{lvl_reg}};
   assign o_clk_n = i_mask_n & {NUM_STAGES{lvl_reg}};
   assign o_gpio  = i_mask_g & {NUM_GPIO{lvl_reg}};
   assign o_busy  = (left_reg != 8'h00);
endmodule : ref_source_model
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the reference input conditioning block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ref_input_pkg::*;
   logic i_core_clk;
   logic i_sys_rst = 1'b1;
   logic [7:0] clk_p, clk_n, mp = 8'h00, mn = 8'h00, burst = 8'h00, vctrl = 8'h80, buf_nmos;
   logic [15:0] gpio, mg = 16'h0000, dis = 16'h0000, sync_en = 16'h0000, ref_edge, sync_flag;
   logic [15:0][3:0] sync_as = '0, sync_as_o;
   logic [15:0][7:0] cnt = '0, e;
   stage_cfg_t [7:0] cfg = '0;
   freq_t [15:0] freq = '0, freq_o;
   sys_pll_ctrl_t otp_c = '0, eep_c = '0, host_ctrl = '0, pll_ctrl, exp_c;
   logic otp_en = 1'b0, otp_valid = 1'b0, eep_en = 1'b1, eep_valid = 1'b0, seq_done = 1'b0, host_wr = 1'b0;
   logic lol_gpio_en = 1'b0, start = 1'b0, busy, loaded, reject, lol, gpio_lol, ok;
   sys_pll_ctrl_t wv [6] = '{11'h46b, 11'h46c, 11'h22c, 11'h22d, 11'h000, 11'h7ff};
   logic [3:0] pin_of [8] = '{4'h0, 4'hf, 4'he, 4'hd, 4'hc, 4'hb, 4'ha, 4'h3};
   int num_errors = 0;
   int samples_checked = 0;

   reference_input_conditioning reference_input_conditioning_inst (
      .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_clk_p(clk_p), .i_clk_n(clk_n),
      .i_gpio(gpio), .i_stage_cfg(cfg), .i_in_disable(dis), .i_sync_en(sync_en),
      .i_sync_assoc(sync_as), .i_freq(freq), .i_otp_en(otp_en), .i_otp_valid(otp_valid),
      .i_otp_ctrl(otp_c), .i_eeprom_en(eep_en), .i_eeprom_valid(eep_valid), .i_eeprom_ctrl(eep_c),
      .i_reset_seq_done(seq_done), .i_host_wr(host_wr), .i_host_ctrl(host_ctrl), .i_vctrl(vctrl),
      .i_lol_gpio_en(lol_gpio_en), .o_ref_edge(ref_edge), .o_buf_nmos(buf_nmos),
      .o_sync_flag(sync_flag), .o_sync_assoc(sync_as_o), .o_freq(freq_o), .o_pll_ctrl(pll_ctrl),
      .o_pll_loaded(loaded), .o_pll_cfg_reject(reject), .o_pll_lol(lol), .o_gpio_lol(gpio_lol));

   ref_source_model ref_source_model_inst (
      .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_start(start), .i_burst(burst),
      .i_mask_p(mp), .i_mask_n(mn), .i_mask_g(mg), .o_clk_p(clk_p), .o_clk_n(clk_n),
      .o_gpio(gpio), .o_busy(busy));

   // 200 MHz clock
   initial begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end

   // counts edge pulses of every internal clock index
   always @(posedge i_core_clk) begin
      for (int i = 0; i < 16; i++) if (ref_edge[i] === 1'b1) cnt[i] <= cnt[i] + 8'h01;
   end

   task print_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict

   task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // bounded wait for a level; running out ends the run
   task automatic wait_sig(ref logic sig, input logic v, input int lim, input string what);
      #1;
      for (int k = 0; k < lim && sig !== v; k++) @(posedge i_core_clk) #1;
      if (sig !== v) begin
         chk(what, v, sig);
         print_verdict;
      end
   endtask : wait_sig

   task tick(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask : tick

   task burst_run(input logic [7:0] n);
      @(posedge i_core_clk) start <= 1'b1;
      burst <= n;
      @(posedge i_core_clk) start <= 1'b0;
      wait_sig(busy, 1'b0, 100, "burst done");
      tick(12);
   endtask : burst_run

   // seven transitions from low: four rising and three falling edges, then park low
   task measure(input logic [7:0] p, input logic [7:0] n, input logic [15:0] g, input string what);
      @(posedge i_core_clk) mp <= p;
      mn <= n;
      mg <= g;
      tick(3);
      cnt = '0;
      burst_run(8'h07);
      for (int i = 0; i < 16; i++) chk(what, e[i], cnt[i]);
      burst_run(8'h01);
   endtask : measure

   task set_cfg(input in_mode_t m, input logic [7:0] nm, input path_cfg_t p, input path_cfg_t n);
      @(posedge i_core_clk);
      for (int s = 0; s < 8; s++) cfg[s] <= '{m, nm[s], p, n};
   endtask : set_cfg

   // reset, refused write while loading, then the reset-time load
   task do_reset(input logic oe, input logic ov, input logic ee, input logic ev, input sys_pll_ctrl_t oc,
                 input sys_pll_ctrl_t ec, input sys_pll_ctrl_t ex);
      @(posedge i_core_clk) i_sys_rst <= 1'b1;
      {otp_en, otp_valid, eep_en, eep_valid, otp_c, eep_c} <= {oe, ov, ee, ev, oc, ec};
      tick(16);
      @(posedge i_core_clk) i_sys_rst <= 1'b0;
      tick(2);
      #1 chk("lol while loading", 1'b1, lol);
      chk("loaded before done", 1'b0, loaded);
      @(posedge i_core_clk) host_wr <= 1'b1;
      host_ctrl <= 11'h0c8;
      @(posedge i_core_clk) host_wr <= 1'b0;
      #1 chk("reject while loading", 1'b1, reject);
      @(posedge i_core_clk) seq_done <= 1'b1;
      @(posedge i_core_clk) seq_done <= 1'b0;
      #1 chk("pll ctrl after load", ex, pll_ctrl);
      chk("loaded", 1'b1, loaded);
   endtask : do_reset

   initial begin
      for (int s = 0; s < 8; s++) cfg[s] = '{MODE_DIFF, 1'b0, 18'h20000, 18'h20000};
      do_reset(1'b1, 1'b1, 1'b1, 1'b1, 11'h06c, 11'h62c, 11'h06c);
      do_reset(1'b0, 1'b1, 1'b1, 1'b1, 11'h06c, 11'h62c, 11'h62c);
      do_reset(1'b1, 1'b1, 1'b1, 1'b1, 11'h06b, 11'h62c, 11'h62c);
      do_reset(1'b1, 1'b0, 1'b1, 1'b0, 11'h06c, 11'h62c, SYS_PLL_RST);
      do_reset(1'b0, 1'b1, 1'b0, 1'b1, 11'h06c, 11'h62c, SYS_PLL_RST);
      // back-to-back host writes across the feedback divider limits
      exp_c = SYS_PLL_RST;
      for (int i = 0; i <= 6; i++) begin
         @(posedge i_core_clk) host_wr <= (i < 6);
         host_ctrl <= (i < 6) ? wv[i % 6] : 11'h000;
         if (i > 0) begin
            #1 ok = (wv[i-1].fb_div >= 10'h06c) && (wv[i-1].fb_div <= 10'h22c);
            if (ok) exp_c = wv[i-1];
            chk("reject", !ok, reject);
            chk("pll ctrl", exp_c, pll_ctrl);
         end
      end
      // lock window of 0x40 without doubler, 0x30 with it
      @(posedge i_core_clk) vctrl <= 8'hbf;
      lol_gpio_en <= 1'b1;
      wait_sig(lol, 1'b0, 20, "lol clears");
      @(posedge i_core_clk) vctrl <= 8'hc1;
      tick(150);
      #1 chk("lol filtered", 1'b0, lol);
      wait_sig(lol, 1'b1, 100, "lol sets");
      chk("gpio lol", 1'b1, gpio_lol);
      @(posedge i_core_clk) vctrl <= 8'hb8;
      wait_sig(lol, 1'b0, 20, "lol clears wide");
      @(posedge i_core_clk) host_wr <= 1'b1;
      host_ctrl <= 11'h46c;
      @(posedge i_core_clk) host_wr <= 1'b0;
      tick(150);
      #1 chk("lol doubled filtered", 1'b0, lol);
      wait_sig(lol, 1'b1, 100, "lol sets doubled");
      @(posedge i_core_clk) lol_gpio_en <= 1'b0;
      tick(3);
      #1 chk("gpio lol off", 1'b0, gpio_lol);
      // differential only: one clock per stage at its own index
      set_cfg(MODE_DIFF, 8'haa, 18'h20000, 18'h20000);
      for (int i = 0; i < 16; i++) e[i] = (i < 8) ? 8'h04 : 8'h00;
      measure(8'hff, 8'hff, 16'hffff, "diff counts");
      chk("buf select diff", 8'haa, buf_nmos);
      // dual single-ended: negative pins at index plus 8, falling edge chosen there
      set_cfg(MODE_DUAL_SE, 8'hff, 18'h20000, 18'h30000);
      for (int i = 8; i < 16; i++) e[i] = 8'h03;
      measure(8'hff, 8'hff, 16'h0000, "dual se counts");
      chk("buf select dual se", 8'h00, buf_nmos);
      // dividers and inverted paths on four stages, the rest untouched
      set_cfg(MODE_DIFF, 8'h00, 18'h20000, 18'h20000);
      @(posedge i_core_clk) cfg[0].pos <= 18'h00000;
      cfg[1].pos <= 18'h00002;
      cfg[2].pos <= 18'h30000;
      cfg[3].pos <= 18'h10001;
      e = '0;
      e[7:4] = {4{8'h04}};
      e[3:0] = {8'h01, 8'h03, 8'h01, 8'h02};
      measure(8'hff, 8'h00, 16'h0000, "divider counts");
      // differential plus gpio, gpio path undivided, two indices disabled
      set_cfg(MODE_DIFF_GPIO, 8'hff, 18'h20000, 18'h10002);
      @(posedge i_core_clk) dis <= 16'h1004;
      for (int s = 0; s < 8; s++) e[s] = 8'h04;
      for (int s = 0; s < 8; s++) e[s+8] = (16'h5401 >> pin_of[s]) & 16'h0001 ? 8'h03 : 8'h00;
      e[2] = 8'h00;
      e[12] = 8'h00;
      measure(8'hff, 8'hff, 16'h5401, "diff gpio counts");
      // sync designation and nominal frequency fraction
      @(posedge i_core_clk) sync_en <= 16'h0005;
      sync_as[0] <= 4'h9;
      freq[3] <= '{48'h0006_60b9_924d, 16'h009e};
      tick(3);
      #1 chk("sync flag", 16'h0001, sync_flag);
      chk("sync assoc", 4'h9, sync_as_o[0]);
      chk("freq", {48'h0006_60b9_924d, 16'h009e}, freq_o[3]);
      print_verdict;
   end
endmodule : tb
`default_nettype wire
